// ---- logic/hbm_pkg.sv ----
// Purpose: Shared constants and types of the H-bridge motor control block
// Assumes: mclk at 40 MHz
// Notes: Times stand in their own unit; cycle counts derive from them
package hbm_pkg;
  // ********************************
  // Timing
  // ********************************
  localparam int CLK_HZ          = 40_000_000;
  localparam int CLK_PERIOD_NS   = 25;
  localparam int PWM_FREQ_HZ     = 44_500;
  localparam int PWM_PERIOD_CYC  = CLK_HZ / PWM_FREQ_HZ;
  localparam int RAMP_TIME_MS    = 12;
  localparam int RAMP_TIME_CYC   = (CLK_HZ / 1000) * RAMP_TIME_MS;
  localparam int ILIM_DGL_NS     = 3000;
  localparam int ILIM_DGL_CYC    = (ILIM_DGL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OCP_DGL_NS      = 2000;
  localparam int OCP_DGL_CYC     = (OCP_DGL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ILIM_FAULT_MS   = 275;
  localparam int ILIM_FAULT_CYC  = (CLK_HZ / 1000) * ILIM_FAULT_MS;
  // ********************************
  // Widths and counts
  // ********************************
  localparam int DUTY_W   = 10;
  localparam int FILT_W   = 8;
  localparam int SET_W    = 8;
  localparam int VOLT_W   = 10;
  localparam int NUM_FET  = 4;
  localparam int NUM_FILT = 5;
  localparam int NUM_EV   = 4;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam logic [DUTY_W-1:0] DUTY_ZERO = 10'h000;
  localparam logic [DUTY_W-1:0] DUTY_ONE  = 10'h001;
  localparam logic [DUTY_W-1:0] DUTY_FULL = DUTY_W'(PWM_PERIOD_CYC);
  localparam logic [DUTY_W-1:0] PWM_TOP   = DUTY_W'(PWM_PERIOD_CYC - 1);
  localparam logic [FILT_W-1:0] FILT_ZERO = 8'h00;
  localparam logic [FILT_W-1:0] FILT_ONE  = 8'h01;
  // ********************************
  // Registers
  // ********************************
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CLEAR  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ENABLE = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATE  = 8'h0c;
  localparam logic [NUM_EV-1:0] EV_RST     = 4'h0;
  localparam logic [NUM_EV-1:0] ENABLE_RST = 4'h0;
  localparam int EV_ILIM = 0;
  localparam int EV_OCP  = 1;
  localparam int EV_HOT  = 2;
  localparam int EV_LOW_SUPPLY_LOCKOUT = 3;
  // ********************************
  // Direction codes and modes
  // ********************************
  localparam logic [1:0] DIR_COAST = 2'b00;
  localparam logic [1:0] DIR_REV   = 2'b01;
  localparam logic [1:0] DIR_FWD   = 2'b10;
  localparam logic [1:0] DIR_BRAKE = 2'b11;
  typedef enum logic [3:0] {
    HBM_IDLE  = 4'b0001,
    HBM_DRIVE = 4'b0010,
    HBM_BRAKE = 4'b0100,
    HBM_LOCK  = 4'b1000
  } hbm_mode_e;
endpackage : hbm_pkg

// ---- logic/hbm_filt_if.sv ----
// Purpose: Raw level, clear and filtered hit of one deglitch channel
// Assumes: Single mclk domain
// Notes: None
`timescale 1ns/1ps
interface hbm_filt_if;
  logic raw;
  logic clr;
  logic hit;
  modport filt (input raw, input clr, output hit);
  modport user (output raw, output clr, input hit);
endinterface : hbm_filt_if

// ---- logic/hbm_deglitch.sv ----
// Purpose: Pass a level only after it has held longer than LIMIT cycles
// Assumes: raw synchronous to mclk
// Notes: Any drop of raw restarts the count
`timescale 1ns/1ps
module hbm_deglitch #(
  parameter logic [hbm_pkg::FILT_W-1:0] LIMIT = 8'h01
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Channel
  hbm_filt_if.filt f
);
  logic [hbm_pkg::FILT_W-1:0] cnt_q;
  logic [hbm_pkg::FILT_W-1:0] cnt_d;
  logic                       hit_d;
  logic                       full;

  assign full  = cnt_q == LIMIT;
  assign cnt_d = (f.clr || !f.raw) ? hbm_pkg::FILT_ZERO :
                 full ? cnt_q : cnt_q + hbm_pkg::FILT_ONE;
  assign hit_d = f.raw && !f.clr && full;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= hbm_pkg::FILT_ZERO;
      f.hit <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      f.hit <= hit_d;
    end
  end
endmodule : hbm_deglitch

// ---- logic/hbm_top.sv ----
// Purpose: Control and protection logic of one H-bridge motor driver
// Assumes: All inputs synchronous to mclk; analog comparators sit outside
// Notes: Status, clear, enable and state registers on APB
// Behaviour
// - Direction pair 00 coast, 01 reverse, 10 forward, 11 brake.
// - Both direction inputs low: drivers off, low-power sleep except while in overcurrent latch-off.
// - Entering forward or reverse restarts duty at zero, ramps up within 12 ms; switching straight between them keeps the duty.
// - Averaged output over four below setpoint raises duty, above lowers it.
// - On time drives commanded direction; off time both high sides recirculate.
// - Setpoint beyond supply: full duty, regulation off.
// - Sense above limit for over 3 us lowers duty to hold current.
// - Limiting for 275 ms flags a fault on the fault pin.
// - A current-limit fault keeps the motor driven.
// - Both direction inputs low, or power cycle, clear the current-limit fault.
// - Deglitched FET overcurrent turns every FET off, pulls fault low.
// - Overcurrent latch-off holds until power is cycled.
// - High and low side FETs are each watched for overcurrent.
// - Overheat turns FETs off, pulls fault low, sets fault and overheat bits.
// - Bridge resumes by itself once the die has cooled.
// - Low supply disables all, pulls fault low, holds mode, deglitch filters and current-limit fault logic at their reset values.
`timescale 1ns/1ps
module hbm_top #(
  parameter int RAMP_CYC       = hbm_pkg::RAMP_TIME_CYC,
  parameter int ILIM_FAULT_CYC = hbm_pkg::ILIM_FAULT_CYC
) (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  // Host direction and setpoint
  input  wire logic                         direction_input_a,
  input  wire logic                         direction_input_b,
  input  wire logic [hbm_pkg::SET_W-1:0]    voltage_setpoint,
  // Analog front end
  input  wire logic [hbm_pkg::VOLT_W-1:0]   avg_output_volt,
  input  wire logic [hbm_pkg::VOLT_W-1:0]   supply_volt,
  input  wire logic                         shunt_sense_pin,
  input  wire logic [hbm_pkg::NUM_FET-1:0]  fet_overcurrent,
  input  wire logic                         overheat_shutdown,
  input  wire logic                         low_supply_lockout,
  // Bridge and fault
  output logic                              bridge_output_a,
  output logic                              bridge_output_a_oe,
  output logic                              bridge_output_b,
  output logic                              bridge_output_b_oe,
  output logic                              error_signal_low,
  output logic                              low_power_sleep,
  output logic                              irq,
  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [hbm_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [hbm_pkg::DATA_W-1:0]   pwdata,
  output logic      [hbm_pkg::DATA_W-1:0]   prdata,
  output logic                              pready,
  output logic                              pslverr
);
  localparam int FW       = hbm_pkg::FILT_W;
  localparam int DW       = hbm_pkg::DATA_W;
  localparam int NE       = hbm_pkg::NUM_EV;
  localparam int STEP_RAW = RAMP_CYC / hbm_pkg::PWM_PERIOD_CYC;
  localparam int STEP_CYC = (STEP_RAW < 1) ? 1 : STEP_RAW;
  localparam int STEP_W   = $clog2(STEP_CYC + 1);
  localparam int LIM_W    = $clog2(ILIM_FAULT_CYC + 1);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYC - 1);
  localparam logic [STEP_W-1:0] STEP_ONE  = STEP_W'(1);
  localparam logic [LIM_W-1:0]  LIM_LAST  = LIM_W'(ILIM_FAULT_CYC - 1);
  localparam logic [LIM_W-1:0]  LIM_ONE   = LIM_W'(1);

  // ********************************
  // Declarations
  // ********************************
  hbm_pkg::hbm_mode_e          mode_q;
  hbm_pkg::hbm_mode_e          mode_d;
  logic [1:0]                  dir_code;
  logic                        want_idle;
  logic                        want_brake;
  logic                        die_hot;
  logic                        sup_low;
  logic                        ocp_any;
  logic                        lim_hit;
  logic                        in_drive;
  logic                        in_lock;
  logic                        nx_drive;
  logic                        nx_lock;
  logic                        run;
  logic                        full_mode;
  logic [hbm_pkg::SET_W-1:0]   meas;
  logic [hbm_pkg::DUTY_W-1:0]  duty_q;
  logic [hbm_pkg::DUTY_W-1:0]  duty_d;
  logic                        duty_up;
  logic                        duty_dn;
  logic                        up_req;
  logic                        dn_req;
  logic [hbm_pkg::DUTY_W-1:0]  pwm_cnt_q;
  logic [hbm_pkg::DUTY_W-1:0]  pwm_cnt_d;
  logic                        pwm_on;
  logic [STEP_W-1:0]           step_q;
  logic [STEP_W-1:0]           step_d;
  logic                        tick;
  logic [LIM_W-1:0]            lim_cnt_q;
  logic [LIM_W-1:0]            lim_cnt_d;
  logic                        lim_run;
  logic                        lim_done;
  logic                        ilim_fault_q;
  logic                        ilim_fault_d;
  logic                        fault_d;
  logic                        drv_ok;
  logic                        drive_on;
  logic                        out_a_q;
  logic                        out_b_q;
  logic                        oe_q;
  logic                        err_q;
  logic                        sleep_q;
  logic                        hot_q;
  logic                        low_q;
  logic [NE-1:0]               ev;
  logic [NE-1:0]               sts_q;
  logic [NE-1:0]               sts_d;
  logic [NE-1:0]               en_q;
  logic [NE-1:0]               en_d;
  logic [NE-1:0]               clr;
  logic                        irq_q;
  logic                        setup;
  logic                        wr;
  logic                        addr_hit;
  logic [DW-1:0]               rd_word;
  logic [DW-1:0]               state_word;
  logic [DW-1:0]               prdata_q;
  logic                        pready_q;
  logic                        pslverr_q;
  logic [hbm_pkg::NUM_FILT-1:0] filt_raw;
  logic [hbm_pkg::NUM_FILT-1:0] filt_hit;

  // ********************************
  // Decode and filters
  // ********************************
  assign dir_code   = {direction_input_a, direction_input_b};
  assign want_idle  = dir_code == hbm_pkg::DIR_COAST;
  assign want_brake = dir_code == hbm_pkg::DIR_BRAKE;
  assign die_hot    = overheat_shutdown;
  assign sup_low    = low_supply_lockout;
  assign filt_raw   = {shunt_sense_pin, fet_overcurrent};

  hbm_filt_if filt_if [hbm_pkg::NUM_FILT] ();

  // Four FET channels, then the shunt sense channel
  for (genvar g = 0; g < hbm_pkg::NUM_FILT; g++) begin : g_filt
    localparam logic [FW-1:0] LIM = (g < hbm_pkg::NUM_FET) ?
                                    FW'(hbm_pkg::OCP_DGL_CYC) : FW'(hbm_pkg::ILIM_DGL_CYC);
    assign filt_if[g].raw = filt_raw[g];
    assign filt_if[g].clr = sup_low;
    assign filt_hit[g]    = filt_if[g].hit;
    hbm_deglitch #(.LIMIT(LIM)) u_dgl (
      .mclk  (mclk),
      .rst_n (rst_n),
      .f     (filt_if[g])
    );
  end

  assign ocp_any = |filt_hit[hbm_pkg::NUM_FET-1:0];
  assign lim_hit = filt_hit[hbm_pkg::NUM_FET];

  // ********************************
  // Mode machine
  // ********************************
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      hbm_pkg::HBM_LOCK: mode_d = hbm_pkg::HBM_LOCK;
      default: begin
        if (ocp_any) mode_d = hbm_pkg::HBM_LOCK;
        else if (want_idle) mode_d = hbm_pkg::HBM_IDLE;
        else if (want_brake) mode_d = hbm_pkg::HBM_BRAKE;
        else mode_d = hbm_pkg::HBM_DRIVE;
      end
    endcase
    if (sup_low) mode_d = hbm_pkg::HBM_IDLE;
  end

  assign in_drive = mode_q == hbm_pkg::HBM_DRIVE;
  assign in_lock  = mode_q == hbm_pkg::HBM_LOCK;
  assign nx_drive = mode_d == hbm_pkg::HBM_DRIVE;
  assign nx_lock  = mode_d == hbm_pkg::HBM_LOCK;

  // ********************************
  // Duty regulation and PWM
  // ********************************
  // Duty is held at zero outside steady drive, so any entry ramps
  assign run       = in_drive && nx_drive && !die_hot;
  assign full_mode = {voltage_setpoint, 2'b00} > supply_volt;
  assign meas      = avg_output_volt[hbm_pkg::VOLT_W-1:2];
  assign duty_up   = duty_q != hbm_pkg::DUTY_FULL;
  assign duty_dn   = duty_q != hbm_pkg::DUTY_ZERO;
  assign tick      = step_q == STEP_LAST;
  // One step per tick bounds the ramp to the full ramp time
  assign up_req = tick && !lim_hit && duty_up && (full_mode || meas < voltage_setpoint);
  assign dn_req = tick && duty_dn && (lim_hit || (!full_mode && meas > voltage_setpoint));
  assign duty_d = !run ? hbm_pkg::DUTY_ZERO :
                  up_req ? duty_q + hbm_pkg::DUTY_ONE :
                  dn_req ? duty_q - hbm_pkg::DUTY_ONE : duty_q;
  assign step_d    = (!run || tick) ? '0 : step_q + STEP_ONE;
  assign pwm_cnt_d = (!run || pwm_cnt_q == hbm_pkg::PWM_TOP) ?
                     hbm_pkg::DUTY_ZERO : pwm_cnt_q + hbm_pkg::DUTY_ONE;
  assign pwm_on    = (duty_q == hbm_pkg::DUTY_FULL) || (pwm_cnt_q < duty_q);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q    <= hbm_pkg::HBM_IDLE;
      duty_q    <= hbm_pkg::DUTY_ZERO;
      step_q    <= '0;
      pwm_cnt_q <= hbm_pkg::DUTY_ZERO;
    end else begin
      mode_q    <= mode_d;
      duty_q    <= duty_d;
      step_q    <= step_d;
      pwm_cnt_q <= pwm_cnt_d;
    end
  end

  // ********************************
  // Current-limit fault
  // ********************************
  assign lim_run      = lim_hit && in_drive;
  assign lim_done     = lim_cnt_q == LIM_LAST;
  assign lim_cnt_d    = (!lim_run || sup_low) ? '0 :
                        lim_done ? lim_cnt_q : lim_cnt_q + LIM_ONE;
  assign ilim_fault_d = (want_idle || sup_low) ? 1'b0 :
                        ilim_fault_q || (lim_run && lim_done);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lim_cnt_q    <= '0;
      ilim_fault_q <= 1'b0;
    end else begin
      lim_cnt_q    <= lim_cnt_d;
      ilim_fault_q <= ilim_fault_d;
    end
  end

  // ********************************
  // Bridge and fault pin
  // ********************************
  // Fault on current limit alone leaves the bridge running
  assign drv_ok   = (nx_drive || mode_d == hbm_pkg::HBM_BRAKE) && !die_hot;
  assign drive_on = nx_drive && pwm_on;
  assign fault_d  = ilim_fault_d || nx_lock || die_hot || sup_low;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_a_q <= 1'b1;
      out_b_q <= 1'b1;
      oe_q    <= 1'b0;
      err_q   <= 1'b0;
      sleep_q <= 1'b1;
    end else begin
      out_a_q <= drive_on ? direction_input_a : 1'b1;
      out_b_q <= drive_on ? direction_input_b : 1'b1;
      oe_q    <= drv_ok;
      err_q   <= !fault_d;
      sleep_q <= mode_d == hbm_pkg::HBM_IDLE;
    end
  end

  assign bridge_output_a    = out_a_q;
  assign bridge_output_b    = out_b_q;
  assign bridge_output_a_oe = oe_q;
  assign bridge_output_b_oe = oe_q;
  assign error_signal_low   = err_q;
  assign low_power_sleep    = sleep_q;

  // ********************************
  // Events, status and interrupt
  // ********************************
  assign ev[hbm_pkg::EV_ILIM] = ilim_fault_d && !ilim_fault_q;
  assign ev[hbm_pkg::EV_OCP]  = nx_lock && !in_lock;
  assign ev[hbm_pkg::EV_HOT]  = die_hot && !hot_q;
  assign ev[hbm_pkg::EV_LOW_SUPPLY_LOCKOUT] = sup_low && !low_q;
  // Set wins over a clear in the same cycle
  assign sts_d = (sts_q & ~clr) | ev;

  // ********************************
  // APB slave
  // ********************************
  assign setup = psel && !penable;
  assign wr    = psel && penable && pready_q && pwrite;
  assign clr   = (wr && paddr == hbm_pkg::REG_CLEAR) ? pwdata[NE-1:0] : '0;
  assign en_d  = (wr && paddr == hbm_pkg::REG_ENABLE) ? pwdata[NE-1:0] : en_q;
  assign state_word = {6'h00, duty_q, 8'h00, dir_code, sleep_q, !err_q,
                       lim_hit, die_hot, in_lock, ilim_fault_q};

  always_comb begin
    rd_word  = '0;
    addr_hit = 1'b1;
    if (paddr == hbm_pkg::REG_STATUS) rd_word = {{(DW-NE){1'b0}}, sts_q};
    else if (paddr == hbm_pkg::REG_CLEAR) rd_word = '0;
    else if (paddr == hbm_pkg::REG_ENABLE) rd_word = {{(DW-NE){1'b0}}, en_q};
    else if (paddr == hbm_pkg::REG_STATE) rd_word = state_word;
    else addr_hit = 1'b0;
  end

  // Read data and error are caught in setup, so pready is one flop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hot_q     <= 1'b0;
      low_q     <= 1'b0;
      sts_q     <= hbm_pkg::EV_RST;
      en_q      <= hbm_pkg::ENABLE_RST;
      irq_q     <= 1'b0;
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else begin
      hot_q     <= die_hot;
      low_q     <= sup_low;
      sts_q     <= sts_d;
      en_q      <= en_d;
      irq_q     <= |(sts_d & en_d);
      pready_q  <= setup;
      prdata_q  <= setup ? rd_word : prdata_q;
      pslverr_q <= setup ? !addr_hit : pslverr_q;
    end
  end

  assign irq     = irq_q;
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_fwd_ok;
    dir_code == hbm_pkg::DIR_FWD && !die_hot && !sup_low && !ocp_any && !in_lock;
  endsequence
  sequence s_enter;
    !in_drive ##1 in_drive;
  endsequence
  sequence s_cool;
    die_hot ##1 !die_hot ##0 s_fwd_ok;
  endsequence

  property p_fwd_on;
    s_fwd_ok ##0 pwm_on |=> bridge_output_a && !bridge_output_b && bridge_output_a_oe;
  endproperty
  a_fwd_on: assert property (p_fwd_on) else $error("forward drive wrong");
  property p_idle;
    want_idle |=> !bridge_output_a_oe && !bridge_output_b_oe && (low_power_sleep || in_lock);
  endproperty
  a_idle: assert property (p_idle) else $error("coast not off");
  property p_ramp;
    s_enter |-> duty_q == hbm_pkg::DUTY_ZERO ##1 duty_q <= hbm_pkg::DUTY_ONE;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp not from zero");
  property p_reg_up;
    run && tick && !lim_hit && !full_mode && meas < voltage_setpoint && duty_up
      |=> duty_q == $past(duty_q) + hbm_pkg::DUTY_ONE;
  endproperty
  a_reg_up: assert property (p_reg_up) else $error("duty not raised");
  property p_recirc;
    s_fwd_ok ##0 !pwm_on |=> bridge_output_a && bridge_output_b && bridge_output_b_oe;
  endproperty
  a_recirc: assert property (p_recirc) else $error("no recirculation");
  property p_full;
    run && tick && !lim_hit && full_mode && duty_up
      |=> duty_q == $past(duty_q) + hbm_pkg::DUTY_ONE;
  endproperty
  a_full: assert property (p_full) else $error("full duty not sought");
  property p_limit;
    run && tick && lim_hit && duty_dn |=> duty_q == $past(duty_q) - hbm_pkg::DUTY_ONE;
  endproperty
  a_limit: assert property (p_limit) else $error("limit not applied");
  property p_ilim_pin;
    $rose(ilim_fault_q) |-> !error_signal_low;
  endproperty
  a_ilim_pin: assert property (p_ilim_pin) else $error("fault pin high");
  property p_ilim_run;
    ilim_fault_q ##0 s_fwd_ok |=> bridge_output_a_oe && bridge_output_b_oe;
  endproperty
  a_ilim_run: assert property (p_ilim_run) else $error("bridge stopped");
  property p_ilim_clr;
    want_idle |=> !ilim_fault_q;
  endproperty
  a_ilim_clr: assert property (p_ilim_clr) else $error("limit fault kept");
  property p_ocp;
    ocp_any && !sup_low |=> in_lock && !bridge_output_a_oe && !error_signal_low;
  endproperty
  a_ocp: assert property (p_ocp) else $error("overcurrent not shut");
  property p_latch;
    in_lock && !sup_low |=> in_lock && !bridge_output_b_oe;
  endproperty
  a_latch: assert property (p_latch) else $error("latch released");
  property p_low_side;
    filt_hit[1] && !sup_low |=> in_lock;
  endproperty
  a_low_side: assert property (p_low_side) else $error("low side missed");
  property p_hot;
    die_hot && !hot_q && !sup_low
      |=> !bridge_output_a_oe && !error_signal_low && sts_q[hbm_pkg::EV_HOT];
  endproperty
  a_hot: assert property (p_hot) else $error("overheat not shut");
  property p_cool;
    s_cool |=> bridge_output_a_oe;
  endproperty
  a_cool: assert property (p_cool) else $error("no resume");
  property p_low_supply_lockout;
    sup_low |=> !bridge_output_a_oe && !error_signal_low && mode_q == hbm_pkg::HBM_IDLE;
  endproperty
  a_low_supply_lockout: assert property (p_low_supply_lockout) else $error("low supply not held");
  property p_release;
    want_idle && !die_hot && !sup_low && !in_lock && !ocp_any |=> error_signal_low;
  endproperty
  a_release: assert property (p_release) else $error("fault pin stuck");
endmodule : hbm_top

// ---- test/hbm_host_model.sv ----
// Purpose: Host side model driving direction inputs, watching fault pin
// Assumes: Single mclk domain
// Notes: Commands pass as levels only, one edge late
`timescale 1ns/1ps
module hbm_host_model (
  // Clock
  input  wire logic       mclk,
  // Command from bench
  input  wire logic [1:0] cmd,
  // Device pins
  output logic            direction_input_a = 1'b0,
  output logic            direction_input_b = 1'b0,
  input  wire logic       error_signal_low,
  output logic            fault_seen
);
  // ****************
  // Host pins
  // ****************
  // Level changes only, no fast toggling; 00 also clears limit fault
  always @(posedge mclk) begin
    {direction_input_a, direction_input_b} <= cmd;
  end
  assign fault_seen = ~error_signal_low;
endmodule : hbm_host_model

// ---- test/tb_hbridge_motor_control_fault.sv ----
// Purpose: Self-checking bench of the motor control block
// Assumes: Short ramp and limit-fault counts
// Notes: Status model kept as an integer
`timescale 1ns/1ps
module tb_hbridge_motor_control_fault;
  logic mclk, rst_n, direction_input_a, direction_input_b, shunt_sense_pin;
  logic overheat_shutdown, low_supply_lockout, psel, penable, pwrite, fault_seen;
  logic [7:0] voltage_setpoint, paddr;
  logic [9:0] avg_output_volt, supply_volt, d1;
  logic [3:0] fet_overcurrent;
  logic [31:0] pwdata, prdata, r;
  logic [1:0] cmd;
  logic bridge_output_a, bridge_output_a_oe, bridge_output_b, bridge_output_b_oe;
  logic error_signal_low, low_power_sleep, irq, pready, pslverr;
  int bad_count, checks_done, sts;
  hbm_top #(.RAMP_CYC(9000), .ILIM_FAULT_CYC(200)) uut (.mclk, .rst_n, .direction_input_a,
    .direction_input_b, .voltage_setpoint, .avg_output_volt, .supply_volt, .shunt_sense_pin,
    .fet_overcurrent, .overheat_shutdown, .low_supply_lockout, .bridge_output_a,
    .bridge_output_a_oe, .bridge_output_b, .bridge_output_b_oe, .error_signal_low,
    .low_power_sleep, .irq, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  hbm_host_model host (.mclk, .cmd, .direction_input_a, .direction_input_b,
    .error_signal_low, .fault_seen);
  // ****************
  // Tasks
  // ****************
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk) penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0; penable <= 1'b0;
    // One idle edge so a following call never re-drives psel in this step
    @(posedge mclk);
  endtask : apb
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // ****************
  // Stimulus
  // ****************
  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    cyc(20000);
    bad_count++;
    tally_and_finish;
  end
  initial begin
    {rst_n, cmd, shunt_sense_pin, overheat_shutdown, low_supply_lockout} = '0;
    {psel, penable, pwrite, paddr, pwdata, fet_overcurrent, avg_output_volt} = '0;
    voltage_setpoint = 8'h80; supply_volt = 10'h3ff; sts = 0;
    void'($urandom(62));
    cyc(8); rst_n <= 1'b1; cyc(3);
    chk("fault", 1, error_signal_low);
    chk("sleep", 1, low_power_sleep);
    for (int i = 0; i < 4; i++) begin
      cmd <= 2'(i); cyc(4);
      chk("oe", i != 0, bridge_output_a_oe & bridge_output_b_oe);
      if (i != 0) chk("recirc", 2'b11, {bridge_output_a, bridge_output_b});
    end
    $display("test table done");
    cmd <= 2'b10; cyc(400); apb(0, 8'h0c, 0); d1 = r[25:16];
    chk("ramp", 1, d1 >= 30 && d1 <= 50);
    for (int k = 0; k < 900 && {bridge_output_a, bridge_output_b} != 2'b10; k++) cyc(1);
    chk("fwd", 2'b10, {bridge_output_a, bridge_output_b});
    apb(0, 8'h0c, 0); d1 = r[25:16];
    avg_output_volt <= 10'h3ff; cyc(200); apb(0, 8'h0c, 0);
    chk("lower", 1, r[25:16] < d1);
    cmd <= 2'b11; cyc(4); cmd <= 2'b10; cyc(3); apb(0, 8'h0c, 0);
    chk("restart", 1, r[25:16] < 2);
    $display("test ramp done");
    shunt_sense_pin <= 1'b1; cyc(400); sts |= 1;
    chk("limfault", 0, error_signal_low);
    chk("seen", 1, fault_seen);
    chk("keeps", 1, bridge_output_a_oe);
    shunt_sense_pin <= 1'b0; cmd <= 2'b00; cyc(4);
    chk("limclr", 1, error_signal_low);
    apb(1, 8'h08, 32'hf); apb(0, 8'h08, 0);
    chk("enable", 32'hf, r);
    apb(0, 8'h00, 0); chk("status", sts, r);
    chk("irq", 1, irq);
    apb(1, 8'h04, 32'hf); sts = 0; cyc(2);
    chk("irqclr", 0, irq);
    apb(0, 8'h40, 0); chk("slverr", 1, pslverr);
    $display("test regs done");
    cmd <= 2'b10; overheat_shutdown <= 1'b1; cyc(4); sts |= 4;
    chk("hot", 2'b00, {bridge_output_a_oe, error_signal_low});
    overheat_shutdown <= 1'b0; cyc(4);
    chk("cool", 2'b11, {bridge_output_a_oe, error_signal_low});
    fet_overcurrent <= 4'(1 << ($urandom % 4)); cyc(90); fet_overcurrent <= '0; cyc(4);
    sts |= 2;
    chk("ocp", 2'b00, {bridge_output_b_oe, error_signal_low});
    cmd <= 2'b11; cyc(4);
    chk("latch", 0, bridge_output_b_oe);
    low_supply_lockout <= 1'b1; cyc(3); sts |= 8;
    chk("low_supply_lockout", 2'b00, {bridge_output_a_oe, error_signal_low});
    low_supply_lockout <= 1'b0; cyc(4);
    chk("resume", 2'b11, {bridge_output_a_oe, error_signal_low});
    apb(0, 8'h00, 0); chk("status", sts, r);
    $display("test protect done");
    tally_and_finish;
  end
endmodule : tb_hbridge_motor_control_fault
